// *** rtl/spr_pkg.sv ***
package spr_pkg;
	localparam int SPR_W = 32;
	localparam int SPR_NUM_W = 10;
	localparam int SPR_RB_W = 30;
	localparam int SPR_DCR_W = 10;
	// number bit that marks a supervisor-only register
	localparam int SPR_PRIV_BIT = 4;
	localparam int SPR_MSR_PR = 14;
	localparam logic [31:0] SPR_ZERO = 32'h0000_0000;
	localparam logic [31:0] SPR_DBG_STAT_RST = 32'h1000_0000;
	localparam logic [31:0] SPR_WDOG_RST_STAT_MASK = 32'h3000_0000;
	localparam logic [1:0] SPR_PC_LOW = 2'h0;
	localparam logic [1:0] SPR_LANE_LAST = 2'h3;
	localparam logic [9:0] SPR_N_INT_EXC = 10'h001;
	localparam logic [9:0] SPR_N_LINK = 10'h008;
	localparam logic [9:0] SPR_N_COUNT = 10'h009;
	localparam logic [9:0] SPR_N_SAVE0 = 10'h01A;
	localparam logic [9:0] SPR_N_PROC_ID = 10'h030;
	localparam logic [9:0] SPR_N_CRIT_SAVE0 = 10'h03A;
	localparam logic [9:0] SPR_N_EXC_SYN = 10'h03E;
	localparam logic [9:0] SPR_N_USER_SCR = 10'h100;
	localparam logic [9:0] SPR_N_TB_LO_RD = 10'h10C;
	localparam logic [9:0] SPR_N_TB_HI_RD = 10'h10D;
	localparam logic [9:0] SPR_N_GEN_SCR0 = 10'h110;
	localparam logic [9:0] SPR_N_TB_LO_WR = 10'h11C;
	localparam logic [9:0] SPR_N_TB_HI_WR = 10'h11D;
	localparam logic [9:0] SPR_N_DBG_STAT = 10'h130;
	localparam logic [9:0] SPR_N_DBG_CTL0 = 10'h134;
	localparam logic [9:0] SPR_N_DBG_CTL1 = 10'h135;
	localparam logic [9:0] SPR_N_DBG_CTL2 = 10'h136;
	localparam logic [9:0] SPR_N_IA_CMP1 = 10'h138;
	localparam logic [9:0] SPR_N_IA_CMP2 = 10'h139;
	localparam logic [9:0] SPR_N_IA_CMP3 = 10'h13A;
	localparam logic [9:0] SPR_N_IA_CMP4 = 10'h13B;
	localparam logic [9:0] SPR_N_DA_CMP1 = 10'h13C;
	localparam logic [9:0] SPR_N_DA_CMP2 = 10'h13D;
	localparam logic [9:0] SPR_N_TMR_STAT = 10'h150;
	localparam logic [9:0] SPR_N_TMR_CTL = 10'h154;
	localparam logic [9:0] SPR_N_DBG_CTL3 = 10'h231;
	localparam logic [9:0] SPR_N_MCHK_SYN = 10'h23C;
	localparam logic [9:0] SPR_N_DBG_SAVE0 = 10'h23E;
	localparam logic [9:0] SPR_N_TLB_CFG0 = 10'h2B0;
	localparam logic [9:0] SPR_N_TLB_CFG1 = 10'h2B1;
	localparam logic [9:0] SPR_N_IMPL0 = 10'h3F0;
	localparam logic [9:0] SPR_N_IMPL1 = 10'h3F1;
	localparam logic [9:0] SPR_N_BR_UNIT = 10'h3F5;
	localparam int SPR_NSTORE = 29;
	typedef enum logic [4:0] {SPR_I_INT_EXC, SPR_I_LINK, SPR_I_COUNT, SPR_I_SAVE0, SPR_I_PROC_ID,
		SPR_I_CRIT_SAVE0, SPR_I_EXC_SYN, SPR_I_USER_SCR, SPR_I_TB_LO, SPR_I_TB_HI, SPR_I_GEN_SCR0,
		SPR_I_DBG_STAT, SPR_I_DBG_CTL0, SPR_I_DBG_CTL1, SPR_I_DBG_CTL2, SPR_I_IA_CMP1, SPR_I_IA_CMP2,
		SPR_I_IA_CMP3, SPR_I_IA_CMP4, SPR_I_DA_CMP1, SPR_I_DA_CMP2, SPR_I_TMR_STAT, SPR_I_TMR_CTL,
		SPR_I_DBG_CTL3, SPR_I_MCHK_SYN, SPR_I_DBG_SAVE0, SPR_I_IMPL0, SPR_I_IMPL1, SPR_I_BR_UNIT} spr_idx_t;
	typedef enum logic [2:0] {SPR_K_PLAIN, SPR_K_W1C, SPR_K_RD_ONLY, SPR_K_WR_ONLY, SPR_K_CFG} spr_kind_t;
	typedef enum logic [2:0] {SPR_E_NONE, SPR_E_ILLEGAL, SPR_E_UNIMPL, SPR_E_FP_UNAVAIL, SPR_E_ALIGN,
		SPR_E_PRIV, SPR_E_BYTE_ORDER} spr_exc_t;
	typedef enum logic [3:0] {SPR_OP_PLAIN, SPR_OP_WIDE64, SPR_OP_STRING, SPR_OP_FLOAT, SPR_OP_DCR_IDX,
		SPR_OP_APID, SPR_OP_CACHE, SPR_OP_BLK_ZERO, SPR_OP_BLK_INVAL, SPR_OP_DCR, SPR_OP_STORE_COND,
		SPR_OP_RET_INT, SPR_OP_RET_CRIT, SPR_OP_RET_DBG, SPR_OP_BR_LINK, SPR_OP_BR_COUNT} spr_op_t;
	typedef struct packed {
		logic hit;
		spr_idx_t idx;
		spr_kind_t kind;
	} spr_map_t;
	function automatic spr_map_t spr_mk(input spr_idx_t i, input spr_kind_t k);
		spr_mk = '{hit: 1'b1, idx: i, kind: k};
	endfunction
	function automatic spr_map_t spr_map(input logic [9:0] n);
		case (n)
			SPR_N_INT_EXC: spr_map = spr_mk(SPR_I_INT_EXC, SPR_K_PLAIN);
			SPR_N_LINK: spr_map = spr_mk(SPR_I_LINK, SPR_K_PLAIN);
			SPR_N_COUNT: spr_map = spr_mk(SPR_I_COUNT, SPR_K_PLAIN);
			SPR_N_SAVE0: spr_map = spr_mk(SPR_I_SAVE0, SPR_K_PLAIN);
			SPR_N_PROC_ID: spr_map = spr_mk(SPR_I_PROC_ID, SPR_K_PLAIN);
			SPR_N_CRIT_SAVE0: spr_map = spr_mk(SPR_I_CRIT_SAVE0, SPR_K_PLAIN);
			SPR_N_EXC_SYN: spr_map = spr_mk(SPR_I_EXC_SYN, SPR_K_PLAIN);
			SPR_N_USER_SCR: spr_map = spr_mk(SPR_I_USER_SCR, SPR_K_PLAIN);
			SPR_N_TB_LO_RD: spr_map = spr_mk(SPR_I_TB_LO, SPR_K_RD_ONLY);
			SPR_N_TB_HI_RD: spr_map = spr_mk(SPR_I_TB_HI, SPR_K_RD_ONLY);
			SPR_N_GEN_SCR0: spr_map = spr_mk(SPR_I_GEN_SCR0, SPR_K_PLAIN);
			SPR_N_TB_LO_WR: spr_map = spr_mk(SPR_I_TB_LO, SPR_K_WR_ONLY);
			SPR_N_TB_HI_WR: spr_map = spr_mk(SPR_I_TB_HI, SPR_K_WR_ONLY);
			SPR_N_DBG_STAT: spr_map = spr_mk(SPR_I_DBG_STAT, SPR_K_W1C);
			SPR_N_DBG_CTL0: spr_map = spr_mk(SPR_I_DBG_CTL0, SPR_K_PLAIN);
			SPR_N_DBG_CTL1: spr_map = spr_mk(SPR_I_DBG_CTL1, SPR_K_PLAIN);
			SPR_N_DBG_CTL2: spr_map = spr_mk(SPR_I_DBG_CTL2, SPR_K_PLAIN);
			SPR_N_IA_CMP1: spr_map = spr_mk(SPR_I_IA_CMP1, SPR_K_PLAIN);
			SPR_N_IA_CMP2: spr_map = spr_mk(SPR_I_IA_CMP2, SPR_K_PLAIN);
			SPR_N_IA_CMP3: spr_map = spr_mk(SPR_I_IA_CMP3, SPR_K_PLAIN);
			SPR_N_IA_CMP4: spr_map = spr_mk(SPR_I_IA_CMP4, SPR_K_PLAIN);
			SPR_N_DA_CMP1: spr_map = spr_mk(SPR_I_DA_CMP1, SPR_K_PLAIN);
			SPR_N_DA_CMP2: spr_map = spr_mk(SPR_I_DA_CMP2, SPR_K_PLAIN);
			SPR_N_TMR_STAT: spr_map = spr_mk(SPR_I_TMR_STAT, SPR_K_W1C);
			SPR_N_TMR_CTL: spr_map = spr_mk(SPR_I_TMR_CTL, SPR_K_PLAIN);
			SPR_N_DBG_CTL3: spr_map = spr_mk(SPR_I_DBG_CTL3, SPR_K_PLAIN);
			SPR_N_MCHK_SYN: spr_map = spr_mk(SPR_I_MCHK_SYN, SPR_K_PLAIN);
			SPR_N_DBG_SAVE0: spr_map = spr_mk(SPR_I_DBG_SAVE0, SPR_K_PLAIN);
			SPR_N_TLB_CFG0: spr_map = spr_mk(SPR_I_INT_EXC, SPR_K_CFG);
			SPR_N_TLB_CFG1: spr_map = spr_mk(SPR_I_INT_EXC, SPR_K_CFG);
			SPR_N_IMPL0: spr_map = spr_mk(SPR_I_IMPL0, SPR_K_PLAIN);
			SPR_N_IMPL1: spr_map = spr_mk(SPR_I_IMPL1, SPR_K_PLAIN);
			SPR_N_BR_UNIT: spr_map = spr_mk(SPR_I_BR_UNIT, SPR_K_PLAIN);
			default: spr_map = '{hit: 1'b0, idx: SPR_I_INT_EXC, kind: SPR_K_PLAIN};
		endcase
	endfunction
	// registers left alone by a system reset, apart from timer status, which keeps only its SPR_WDOG_RST_STAT_MASK bits
	function automatic logic spr_keeps(input spr_idx_t i);
		case (i)
			SPR_I_LINK, SPR_I_COUNT, SPR_I_SAVE0, SPR_I_CRIT_SAVE0, SPR_I_USER_SCR, SPR_I_TB_LO, SPR_I_TB_HI,
			SPR_I_GEN_SCR0, SPR_I_DBG_SAVE0, SPR_I_TMR_STAT: spr_keeps = 1'b1;
			default: spr_keeps = 1'b0;
		endcase
	endfunction
endpackage

// *** rtl/spr_op_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface spr_op_if;
	spr_pkg::spr_op_t op;
	logic user;
	logic resv;
	logic [spr_pkg::SPR_DCR_W-1:0] dcr_num;
	logic [31:0] save0;
	logic [31:0] crit_save0;
	logic [31:0] dbg_save0;
	logic [31:0] link;
	logic [31:0] count;
	spr_pkg::spr_exc_t exc;
	logic tgt_valid;
	logic [31:0] tgt;
	logic store_go;
	modport bank (output op, user, resv, dcr_num, save0, crit_save0, dbg_save0, link, count,
		input exc, tgt_valid, tgt, store_go);
	modport legal (input op, user, resv, dcr_num, save0, crit_save0, dbg_save0, link, count,
		output exc, tgt_valid, tgt, store_go);
endinterface
`default_nettype wire

// *** rtl/spr_legal.sv ***
`timescale 1ns/10ps
`default_nettype none
module spr_legal #(
	parameter int DCR_COUNT = 0
) (
	spr_op_if.legal op_if
);
	always_comb
	begin
		op_if.exc = spr_pkg::SPR_E_NONE;
		op_if.tgt_valid = 1'b0;
		op_if.tgt = spr_pkg::SPR_ZERO;
		op_if.store_go = 1'b0;
		case (op_if.op)
			spr_pkg::SPR_OP_WIDE64: op_if.exc = spr_pkg::SPR_E_ILLEGAL;
			spr_pkg::SPR_OP_STRING, spr_pkg::SPR_OP_DCR_IDX, spr_pkg::SPR_OP_APID:
				op_if.exc = spr_pkg::SPR_E_UNIMPL;
			spr_pkg::SPR_OP_FLOAT: op_if.exc = spr_pkg::SPR_E_FP_UNAVAIL;
			spr_pkg::SPR_OP_CACHE: op_if.exc = spr_pkg::SPR_E_NONE;
			spr_pkg::SPR_OP_BLK_ZERO: op_if.exc = spr_pkg::SPR_E_ALIGN;
			spr_pkg::SPR_OP_BLK_INVAL: op_if.exc = op_if.user ? spr_pkg::SPR_E_PRIV : spr_pkg::SPR_E_NONE;
			spr_pkg::SPR_OP_DCR:
				if (32'(op_if.dcr_num) >= DCR_COUNT)
				begin
					op_if.exc = spr_pkg::SPR_E_ILLEGAL;
				end
			// no address compare against the reserving load: the flag alone decides
			spr_pkg::SPR_OP_STORE_COND: op_if.store_go = op_if.resv;
			spr_pkg::SPR_OP_RET_INT:
			begin
				op_if.tgt_valid = 1'b1;
				op_if.tgt = {op_if.save0[31:1], 1'b0};
			end
			spr_pkg::SPR_OP_RET_CRIT:
			begin
				op_if.tgt_valid = 1'b1;
				op_if.tgt = {op_if.crit_save0[31:1], 1'b0};
			end
			spr_pkg::SPR_OP_RET_DBG:
			begin
				op_if.tgt_valid = 1'b1;
				op_if.tgt = {op_if.dbg_save0[31:1], 1'b0};
			end
			spr_pkg::SPR_OP_BR_LINK:
			begin
				op_if.tgt_valid = 1'b1;
				op_if.tgt = {op_if.link[31:1], 1'b0};
			end
			spr_pkg::SPR_OP_BR_COUNT:
			begin
				op_if.tgt_valid = 1'b1;
				op_if.tgt = {op_if.count[31:1], 1'b0};
			end
			default: op_if.exc = spr_pkg::SPR_E_NONE;
		endcase
	end
endmodule
`default_nettype wire

// *** rtl/spr_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
module spr_bank #(
	parameter logic [31:0] TLB_CFG0_VAL = 32'h0000_0000,
	parameter logic [31:0] TLB_CFG1_VAL = 32'h0000_0000,
	parameter int DCR_COUNT = 0
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_por,
	input wire logic [spr_pkg::SPR_RB_W-1:0] i_rst_base,
	input wire logic i_spr_rd,
	input wire logic i_spr_wr,
	input wire logic [spr_pkg::SPR_NUM_W-1:0] i_spr_num,
	input wire logic [31:0] i_spr_wdata,
	input wire logic i_msr_wr,
	input wire logic [31:0] i_msr_wdata,
	input wire logic [31:0] i_timer_status_set,
	input wire logic [31:0] i_debug_status_set,
	input wire logic i_tb_tick,
	input wire logic i_op_valid,
	input wire spr_pkg::spr_op_t i_op,
	input wire logic [spr_pkg::SPR_DCR_W-1:0] i_dcr_num,
	input wire logic i_resv,
	input wire logic i_ls_valid,
	input wire logic i_ls_store,
	input wire logic [1:0] i_ls_addr,
	input wire logic [1:0] i_ls_size,
	input wire logic i_ls_page_cross,
	input wire logic i_ls_miss2,
	input wire logic i_ls_order_change,
	output logic [31:0] o_spr_rdata,
	output logic o_spr_ack,
	output var spr_pkg::spr_exc_t o_exc,
	output logic [31:0] o_pc,
	output logic o_pc_load,
	output logic o_store_go,
	output logic o_user,
	output logic o_ls_ready,
	output logic o_ls_done,
	output logic o_ls_restart,
	output logic o_ls_second
);
	typedef enum {SPR_LS_IDLE, SPR_LS_SECOND} spr_ls_st_t;
	typedef struct packed {
		logic [spr_pkg::SPR_NSTORE-1:0][31:0] regs;
		logic [31:0] machine_state;
		logic [31:0] pc;
		logic pc_load;
		logic [31:0] rdata;
		logic ack;
		spr_pkg::spr_exc_t exc;
		logic store_go;
		spr_ls_st_t ls_st;
		logic ls_ready;
		logic ls_done;
		logic ls_restart;
		logic ls_store;
		logic [spr_pkg::SPR_RB_W-1:0] base_s1;
		logic [spr_pkg::SPR_RB_W-1:0] base_s2;
	} spr_bank_st_t;
	spr_bank_st_t q;
	spr_bank_st_t d;
	spr_pkg::spr_map_t m;
	logic user;
	logic priv_num;
	logic bad_dir;
	logic crosses;
	logic [2:0] lane_end;
	spr_op_if op_if ();
	assign user = q.machine_state[spr_pkg::SPR_MSR_PR];
	assign m = spr_pkg::spr_map(i_spr_num);
	assign priv_num = i_spr_num[spr_pkg::SPR_PRIV_BIT];
	assign bad_dir = (i_spr_rd && m.kind == spr_pkg::SPR_K_WR_ONLY) || (i_spr_wr && m.kind == spr_pkg::SPR_K_RD_ONLY);
	assign lane_end = {1'b0, i_ls_addr} + {1'b0, i_ls_size};
	assign crosses = lane_end > {1'b0, spr_pkg::SPR_LANE_LAST};
	assign op_if.op = i_op_valid ? i_op : spr_pkg::SPR_OP_PLAIN;
	assign op_if.user = user;
	assign op_if.resv = i_resv;
	assign op_if.dcr_num = i_dcr_num;
	assign op_if.save0 = q.regs[spr_pkg::SPR_I_SAVE0];
	assign op_if.crit_save0 = q.regs[spr_pkg::SPR_I_CRIT_SAVE0];
	assign op_if.dbg_save0 = q.regs[spr_pkg::SPR_I_DBG_SAVE0];
	assign op_if.link = q.regs[spr_pkg::SPR_I_LINK];
	assign op_if.count = q.regs[spr_pkg::SPR_I_COUNT];
	spr_legal #(
		.DCR_COUNT(DCR_COUNT)
	) u_legal (
		.op_if(op_if)
	);
	always_comb
	begin
		d = q;
		d.ack = 1'b0;
		d.exc = spr_pkg::SPR_E_NONE;
		d.pc_load = 1'b0;
		d.store_go = 1'b0;
		d.ls_done = 1'b0;
		d.ls_restart = 1'b0;
		d.base_s1 = i_rst_base;
		d.base_s2 = q.base_s1;
		if (i_tb_tick)
		begin
			{d.regs[spr_pkg::SPR_I_TB_HI], d.regs[spr_pkg::SPR_I_TB_LO]} =
				{q.regs[spr_pkg::SPR_I_TB_HI], q.regs[spr_pkg::SPR_I_TB_LO]} + 64'h1;
		end
		if (i_msr_wr)
		begin
			d.machine_state = i_msr_wdata;
		end
		if (i_spr_rd || i_spr_wr)
		begin
			d.ack = 1'b1;
			d.rdata = spr_pkg::SPR_ZERO;
			if (!m.hit || bad_dir)
			begin
				d.exc = (priv_num && user) ? spr_pkg::SPR_E_PRIV : spr_pkg::SPR_E_ILLEGAL;
			end
			else if (priv_num && user)
			begin
				d.exc = spr_pkg::SPR_E_PRIV;
			end
			else if (i_spr_rd)
			begin
				if (m.kind == spr_pkg::SPR_K_CFG)
				begin
					d.rdata = (i_spr_num == spr_pkg::SPR_N_TLB_CFG0) ? TLB_CFG0_VAL : TLB_CFG1_VAL;
				end
				else
				begin
					d.rdata = q.regs[m.idx];
				end
			end
			else if (m.kind == spr_pkg::SPR_K_W1C)
			begin
				d.regs[m.idx] = q.regs[m.idx] & ~i_spr_wdata;
			end
			else if (m.kind != spr_pkg::SPR_K_CFG)
			begin
				d.regs[m.idx] = i_spr_wdata; // writes to configuration words fall through
			end
		end
		// set after clear: an event in the clearing cycle survives
		d.regs[spr_pkg::SPR_I_TMR_STAT] = d.regs[spr_pkg::SPR_I_TMR_STAT] | i_timer_status_set;
		d.regs[spr_pkg::SPR_I_DBG_STAT] = d.regs[spr_pkg::SPR_I_DBG_STAT] | i_debug_status_set;
		if (i_op_valid)
		begin
			if (d.exc == spr_pkg::SPR_E_NONE)
			begin
				d.exc = op_if.exc;
			end
			d.store_go = op_if.store_go;
			if (op_if.tgt_valid)
			begin
				d.pc = op_if.tgt;
				d.pc_load = 1'b1;
			end
		end
		case (q.ls_st)
			SPR_LS_IDLE:
				if (i_ls_valid && q.ls_ready)
				begin
					if (crosses && i_ls_order_change)
					begin
						d.exc = spr_pkg::SPR_E_BYTE_ORDER;
					end
					else if (crosses)
					begin
						// the unit is held for the second word, halving throughput
						d.ls_st = SPR_LS_SECOND;
						d.ls_ready = 1'b0;
						d.ls_store = i_ls_store;
					end
					else
					begin
						d.ls_done = 1'b1;
					end
				end
			SPR_LS_SECOND:
			begin
				d.ls_st = SPR_LS_IDLE;
				d.ls_ready = 1'b1;
				if (i_ls_page_cross && i_ls_miss2)
				begin
					// the first word may be touched twice on the retry
					d.ls_restart = 1'b1;
				end
				else
				begin
					d.ls_done = 1'b1;
				end
			end
			default: d.ls_st = SPR_LS_IDLE;
		endcase
		if (i_reset || i_por)
		begin
			for (int i = 0; i < spr_pkg::SPR_NSTORE; i++)
			begin
				if (i_por || !spr_pkg::spr_keeps(spr_pkg::spr_idx_t'(i)))
				begin
					d.regs[i] = spr_pkg::SPR_ZERO;
				end
			end
			d.regs[spr_pkg::SPR_I_DBG_STAT] = spr_pkg::SPR_DBG_STAT_RST;
			d.regs[spr_pkg::SPR_I_TMR_STAT] = i_por ? spr_pkg::SPR_ZERO :
				(q.regs[spr_pkg::SPR_I_TMR_STAT] & spr_pkg::SPR_WDOG_RST_STAT_MASK);
			d.machine_state = spr_pkg::SPR_ZERO;
			d.pc = {q.base_s2, spr_pkg::SPR_PC_LOW};
			d.pc_load = 1'b0;
			d.rdata = spr_pkg::SPR_ZERO;
			d.ack = 1'b0;
			d.exc = spr_pkg::SPR_E_NONE;
			d.store_go = 1'b0;
			d.ls_st = SPR_LS_IDLE;
			d.ls_ready = 1'b1;
			d.ls_done = 1'b0;
			d.ls_restart = 1'b0;
			d.ls_store = 1'b0;
		end
	end
	always_ff @(posedge i_clk_sys)
	begin
		q <= d;
	end
	assign o_spr_rdata = q.rdata;
	assign o_spr_ack = q.ack;
	assign o_exc = q.exc;
	assign o_pc = q.pc;
	assign o_pc_load = q.pc_load;
	assign o_store_go = q.store_go;
	assign o_user = user;
	assign o_ls_ready = q.ls_ready;
	assign o_ls_done = q.ls_done;
	assign o_ls_restart = q.ls_restart;
	assign o_ls_second = q.ls_store;

	logic [31:0] tstat;
	logic [31:0] dstat;
	logic ok_wr;
	assign tstat = q.regs[spr_pkg::SPR_I_TMR_STAT];
	assign dstat = q.regs[spr_pkg::SPR_I_DBG_STAT];
	assign ok_wr = i_spr_wr && !i_spr_rd && !user && !i_reset && !i_por;

	property p_tstat_w1c;
		@(posedge i_clk_sys) disable iff (i_reset || i_por)
		(ok_wr && i_spr_num == spr_pkg::SPR_N_TMR_STAT && i_timer_status_set == spr_pkg::SPR_ZERO)
		|=> tstat == ($past(tstat) & ~$past(i_spr_wdata));
	endproperty
	a_tstat_w1c: assert property (p_tstat_w1c) else $error("timer status write not clear-only");
	property p_dstat_w1c;
		@(posedge i_clk_sys) disable iff (i_reset || i_por)
		(ok_wr && i_spr_num == spr_pkg::SPR_N_DBG_STAT && i_debug_status_set == spr_pkg::SPR_ZERO)
		|=> dstat == ($past(dstat) & ~$past(i_spr_wdata));
	endproperty
	a_dstat_w1c: assert property (p_dstat_w1c) else $error("debug status write not clear-only");
	property p_pc_base;
		@(posedge i_clk_sys) disable iff (i_por)
		i_reset |=> o_pc == {$past(q.base_s2), spr_pkg::SPR_PC_LOW} && !o_pc_load;
	endproperty
	a_pc_base: assert property (p_pc_base) else $error("reset counter not from base pins");
	property p_reset_vals;
		@(posedge i_clk_sys) disable iff (i_por)
		i_reset |=> dstat == spr_pkg::SPR_DBG_STAT_RST && q.regs[spr_pkg::SPR_I_TMR_CTL] == spr_pkg::SPR_ZERO
			&& !o_user && q.regs[spr_pkg::SPR_I_IMPL0] == spr_pkg::SPR_ZERO;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("wrong value after system reset");
	property p_keep;
		@(posedge i_clk_sys) disable iff (i_por)
		i_reset |=> q.regs[spr_pkg::SPR_I_LINK] == $past(q.regs[spr_pkg::SPR_I_LINK])
			&& q.regs[spr_pkg::SPR_I_SAVE0] == $past(q.regs[spr_pkg::SPR_I_SAVE0]);
	endproperty
	a_keep: assert property (p_keep) else $error("kept register changed by system reset");
	property p_tstat_rst;
		@(posedge i_clk_sys) disable iff (i_por)
		i_reset |=> (tstat & ~spr_pkg::SPR_WDOG_RST_STAT_MASK) == spr_pkg::SPR_ZERO
			&& (tstat & spr_pkg::SPR_WDOG_RST_STAT_MASK) == ($past(tstat) & spr_pkg::SPR_WDOG_RST_STAT_MASK);
	endproperty
	a_tstat_rst: assert property (p_tstat_rst) else $error("timer status reset wrong");
	property p_ret_int;
		@(posedge i_clk_sys) disable iff (i_reset || i_por)
		(i_op_valid && i_op == spr_pkg::SPR_OP_RET_INT) |=> o_pc_load && o_pc == {$past(op_if.save0[31:1]), 1'b0};
	endproperty
	a_ret_int: assert property (p_ret_int) else $error("interrupt return target wrong");
	property p_two_cycle;
		@(posedge i_clk_sys) disable iff (i_reset || i_por)
		(i_ls_valid && o_ls_ready && crosses && !i_ls_order_change) |=> !o_ls_ready ##1 (o_ls_ready && (o_ls_done ^ o_ls_restart));
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("misaligned access not two cycles");
	property p_priv_exc;
		@(posedge i_clk_sys) disable iff (i_reset || i_por)
		((i_spr_rd ^ i_spr_wr) && !m.hit && priv_num && user && !i_ls_valid) |=> o_exc == spr_pkg::SPR_E_PRIV;
	endproperty
	a_priv_exc: assert property (p_priv_exc) else $error("invalid register privilege response wrong");
	property p_store_cond;
		@(posedge i_clk_sys) disable iff (i_reset || i_por)
		(i_op_valid && i_op == spr_pkg::SPR_OP_STORE_COND && i_resv) |=> o_store_go;
	endproperty
	a_store_cond: assert property (p_store_cond) else $error("conditional store not performed");
	property p_br_link;
		@(posedge i_clk_sys) disable iff (i_reset || i_por)
		(i_op_valid && i_op == spr_pkg::SPR_OP_BR_LINK) |=> o_pc_load && o_pc == {$past(op_if.link[31:1]), 1'b0};
	endproperty
	a_br_link: assert property (p_br_link) else $error("link branch target wrong");
	property p_wide_illegal;
		@(posedge i_clk_sys) disable iff (i_reset || i_por)
		(i_op_valid && i_op == spr_pkg::SPR_OP_WIDE64 && !i_spr_rd && !i_spr_wr && !i_ls_valid)
			|=> o_exc == spr_pkg::SPR_E_ILLEGAL;
	endproperty
	a_wide_illegal: assert property (p_wide_illegal) else $error("wide instruction not illegal");
	property p_order_exc;
		@(posedge i_clk_sys) disable iff (i_reset || i_por)
		(i_ls_valid && o_ls_ready && crosses && i_ls_order_change)
			|=> o_exc == spr_pkg::SPR_E_BYTE_ORDER && !o_ls_done;
	endproperty
	a_order_exc: assert property (p_order_exc) else $error("byte order change not flagged");
	property p_restart;
		@(posedge i_clk_sys) disable iff (i_reset || i_por)
		(q.ls_st == SPR_LS_SECOND && i_ls_page_cross && i_ls_miss2) |=> o_ls_restart && !o_ls_done;
	endproperty
	a_restart: assert property (p_restart) else $error("second part miss not restarted");
	property p_cfg_fixed;
		@(posedge i_clk_sys) disable iff (i_reset || i_por)
		(i_spr_rd && !i_spr_wr && !user && i_spr_num == spr_pkg::SPR_N_TLB_CFG0) |=> o_spr_rdata == TLB_CFG0_VAL;
	endproperty
	a_cfg_fixed: assert property (p_cfg_fixed) else $error("configuration word not fixed");
	c_restart: cover property (@(posedge i_clk_sys) o_ls_restart);
	c_mis_done: cover property (@(posedge i_clk_sys) !o_ls_ready ##1 o_ls_done);
	c_w1c: cover property (@(posedge i_clk_sys) ok_wr && i_spr_num == spr_pkg::SPR_N_TMR_STAT);
	c_branch: cover property (@(posedge i_clk_sys) o_pc_load);
	c_priv: cover property (@(posedge i_clk_sys) o_exc == spr_pkg::SPR_E_PRIV);
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic i_clk_sys, i_reset, i_por, i_spr_rd, i_spr_wr, i_msr_wr, i_tb_tick, i_op_valid, i_resv;
	logic [29:0] i_rst_base;
	logic [9:0] i_spr_num, i_dcr_num;
	logic [31:0] i_spr_wdata, i_msr_wdata, i_timer_status_set, i_debug_status_set, o_spr_rdata, o_pc, rd;
	logic i_ls_valid, i_ls_store, i_ls_page_cross, i_ls_miss2, i_ls_order_change;
	logic [1:0] i_ls_addr, i_ls_size;
	logic o_spr_ack, o_pc_load, o_store_go, o_user, o_ls_ready, o_ls_done, o_ls_restart, o_ls_second;
	spr_pkg::spr_op_t i_op;
	spr_pkg::spr_exc_t o_exc, ex;
	int error_cnt, n_tests;
	logic [9:0] zr[11] = '{10'h001, 10'h030, 10'h03E, 10'h134, 10'h138, 10'h13C, 10'h154, 10'h23C, 10'h3F0,
		10'h3F1, 10'h3F5};
	spr_bank dut (.i_clk_sys, .i_reset, .i_por, .i_rst_base, .i_spr_rd, .i_spr_wr, .i_spr_num, .i_spr_wdata,
		.i_msr_wr, .i_msr_wdata, .i_timer_status_set, .i_debug_status_set, .i_tb_tick, .i_op_valid, .i_op,
		.i_dcr_num, .i_resv, .i_ls_valid, .i_ls_store, .i_ls_addr, .i_ls_size, .i_ls_page_cross, .i_ls_miss2,
		.i_ls_order_change, .o_spr_rdata, .o_spr_ack, .o_exc, .o_pc, .o_pc_load, .o_store_go, .o_user,
		.o_ls_ready, .o_ls_done, .o_ls_restart, .o_ls_second);
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chke(input string nm, input spr_pkg::spr_exc_t e, input spr_pkg::spr_exc_t g);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// every task starts and ends just after a falling edge
	task automatic rst(input logic por);
		i_reset = 1'b1;
		i_por = por;
		repeat (10) @(negedge i_clk_sys);
		i_reset = 1'b0;
		i_por = 1'b0;
		chk32("pc", {i_rst_base, 2'h0}, o_pc);
	endtask
	task automatic acc(input logic w, input logic [9:0] n, input logic [31:0] d);
		i_spr_rd = !w;
		i_spr_wr = w;
		i_spr_num = n;
		i_spr_wdata = d;
		@(negedge i_clk_sys);
		i_spr_rd = 1'b0;
		i_spr_wr = 1'b0;
		rd = o_spr_rdata;
		ex = o_exc;
		chk32("ack", 32'h1, {31'h0, o_spr_ack});
		// idle cycle so the next call does not re-raise a strobe in the same step
		@(negedge i_clk_sys);
	endtask
	task automatic rdc(input logic [9:0] n, input logic [31:0] e);
		acc(1'b0, n, 32'h0);
		chk32("rdata", e, rd);
		chke("rd exc", spr_pkg::SPR_E_NONE, ex);
	endtask
	task automatic opx(input spr_pkg::spr_op_t op, input logic r);
		i_op_valid = 1'b1;
		i_op = op;
		i_resv = r;
		@(negedge i_clk_sys);
		i_op_valid = 1'b0;
		ex = o_exc;
		// pulses only stand one cycle, so they are kept here
		rd = {30'h0, o_store_go, o_pc_load};
		@(negedge i_clk_sys);
	endtask
	task automatic machine_state(input logic [31:0] v);
		i_msr_wr = 1'b1;
		i_msr_wdata = v;
		@(negedge i_clk_sys);
		i_msr_wr = 1'b0;
		@(negedge i_clk_sys);
	endtask
	// packs ready,done,restart one and two cycles after the take, and the store flag
	task automatic lsx(input logic st, input logic [1:0] a, input logic [1:0] s, input logic m2, input logic oc);
		i_ls_valid = 1'b1;
		i_ls_store = st;
		i_ls_addr = a;
		i_ls_size = s;
		i_ls_page_cross = m2;
		i_ls_miss2 = m2;
		i_ls_order_change = oc;
		@(negedge i_clk_sys);
		i_ls_valid = 1'b0;
		ex = o_exc;
		rd = {25'h0, o_ls_second, o_ls_ready, o_ls_done, o_ls_restart, 3'h0};
		@(negedge i_clk_sys);
		rd[2:0] = {o_ls_ready, o_ls_done, o_ls_restart};
		i_ls_miss2 = 1'b0;
		i_ls_page_cross = 1'b0;
		i_ls_order_change = 1'b0;
		@(negedge i_clk_sys);
	endtask
	initial
	begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	initial
	begin
		repeat (3000) @(posedge i_clk_sys);
		error_cnt++;
		$display("[FAIL] watchdog expired");
		wrap_up();
	end
	initial
	begin
		{i_spr_rd, i_spr_wr, i_msr_wr, i_tb_tick, i_op_valid, i_resv, i_ls_valid, i_ls_store} = 8'h00;
		{i_ls_page_cross, i_ls_miss2, i_ls_order_change, i_ls_addr, i_ls_size} = 7'h00;
		{i_spr_num, i_dcr_num, i_spr_wdata, i_msr_wdata} = 84'h0;
		{i_timer_status_set, i_debug_status_set} = 64'h0;
		i_op = spr_pkg::SPR_OP_PLAIN;
		i_rst_base = 30'h2AAA_5555;
		rst(1'b1);
		i_timer_status_set = 32'hF000_00F0;
		@(negedge i_clk_sys);
		i_timer_status_set = 32'h0;
		acc(1'b1, 10'h150, 32'h1000_0010);
		rdc(10'h150, 32'hE000_00E0);
		foreach (zr[i]) acc(1'b1, zr[i], 32'hFFFF_FFFF);
		acc(1'b1, 10'h008, 32'h1234_5679);
		i_rst_base = 30'h1555_AAAA;
		// time base ticks that the system reset must not lose
		i_tb_tick = 1'b1;
		repeat (3) @(negedge i_clk_sys);
		i_tb_tick = 1'b0;
		rst(1'b0);
		foreach (zr[i]) rdc(zr[i], 32'h0);
		rdc(10'h130, 32'h1000_0000);
		rdc(10'h008, 32'h1234_5679);
		rdc(10'h10C, 32'h0000_0003);
		rdc(10'h150, 32'h2000_0000);
		i_debug_status_set = 32'h0000_0F00;
		@(negedge i_clk_sys);
		i_debug_status_set = 32'h0;
		acc(1'b1, 10'h130, 32'h1000_0300);
		rdc(10'h130, 32'h0000_0C00);
		acc(1'b1, 10'h2B0, 32'hFFFF_FFFF);
		rdc(10'h2B0, 32'h0);
		rdc(10'h001, 32'h0);
		acc(1'b0, 10'h3FF, 32'h0);
		chke("sup invalid", spr_pkg::SPR_E_ILLEGAL, ex);
		machine_state(32'h0000_4000);
		chk32("user", 32'h1, {31'h0, o_user});
		acc(1'b0, 10'h3FF, 32'h0);
		chke("user invalid hi", spr_pkg::SPR_E_PRIV, ex);
		acc(1'b1, 10'h10C, 32'h0);
		chke("user invalid lo", spr_pkg::SPR_E_ILLEGAL, ex);
		opx(spr_pkg::SPR_OP_BLK_INVAL, 1'b0);
		chke("user invalidate", spr_pkg::SPR_E_PRIV, ex);
		machine_state(32'h0);
		for (int i = 0; i < 9; i++)
		begin
			opx(spr_pkg::spr_op_t'(i + 1), 1'b0);
			chke("op exc", spr_pkg::spr_exc_t'(3'(36'h1_0402_2321 >> (4 * i))), ex);
		end
		opx(spr_pkg::SPR_OP_STORE_COND, 1'b1);
		chk32("store", 32'h1, {31'h0, rd[1]});
		opx(spr_pkg::SPR_OP_STORE_COND, 1'b0);
		chk32("no store", 32'h0, {31'h0, rd[1]});
		for (int i = 0; i < 5; i++)
		begin
			acc(1'b1, (i == 0) ? 10'h01A : (i == 1) ? 10'h03A : (i == 2) ? 10'h23E : 10'h005 + 10'(i),
				32'h4000_0003 ^ (i << 8));
			opx(spr_pkg::spr_op_t'(i + 11), 1'b0);
			chk32("target", 32'h4000_0002 ^ (i << 8), o_pc);
			chk32("pc load", 32'h1, {31'h0, rd[0]});
		end
		lsx(1'b0, 2'h2, 2'h1, 1'b0, 1'b0);
		chk32("ls aligned", 32'h34, rd);
		lsx(1'b0, 2'h3, 2'h1, 1'b0, 1'b0);
		chk32("ls cross load", 32'h06, rd);
		lsx(1'b1, 2'h1, 2'h3, 1'b0, 1'b0);
		chk32("ls cross store", 32'h46, rd);
		lsx(1'b0, 2'h3, 2'h1, 1'b1, 1'b0);
		chk32("ls restart", 32'h05, rd);
		lsx(1'b0, 2'h3, 2'h1, 1'b0, 1'b1);
		chke("ls order", spr_pkg::SPR_E_BYTE_ORDER, ex);
		chk32("ls order done", 32'h0, rd & 32'h12);
		wrap_up();
	end
endmodule
`default_nettype wire
